// [logic/pic_cfg.svh]
// constants for the two-level priority interrupt controller
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_ENABLE 4'h0
`define OFS_PRIORITY 4'h4
`define OFS_TIMER_CONTROL 4'h8
`define OFS_STATUS 4'hC

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EN_GLOBAL_BIT 7
`define TC_EXT0_TRIG_BIT 0
`define TC_EXT0_FLAG_BIT 1
`define TC_EXT1_TRIG_BIT 2
`define TC_EXT1_FLAG_BIT 3
`define TC_TIMER0_FLAG_BIT 5
`define TC_TIMER1_FLAG_BIT 7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ENABLE_RESET 8'h00
`define PRIORITY_RESET 6'h00
`define TRIGGER_RESET 2'h0

// ----------------------------------------------------------------
// vectors, in polling order
// ----------------------------------------------------------------
`define VEC_EXT0 16'h0003
`define VEC_TIMER0 16'h000B
`define VEC_EXT1 16'h0013
`define VEC_TIMER1 16'h001B
`define VEC_SERIAL 16'h0023
`define VEC_TIMER2 16'h002B

// ----------------------------------------------------------------
// timing, in machine cycles
// ----------------------------------------------------------------
`define CALL_CYCLES 2

`endif

// [logic/pic_pkg.sv]
// types for the two-level priority interrupt controller
package pic_pkg;

    typedef enum logic [1:0] {
        CALL_IDLE,
        CALL_PUSH,
        CALL_LOAD
    } call_state_t;

    typedef struct packed {
        logic pin_q;
        logic flag;
    } detect_state_t;

    typedef struct packed {
        logic [7:0] enable;
        logic [5:0] level_select;
        logic [1:0] trigger;
        logic timer0_flag;
        logic timer1_flag;
        logic [5:0] sample;
        logic in_prog_hi;
        logic in_prog_lo;
        call_state_t call;
        logic [15:0] vector;
        logic pop_pc;
        logic bus_wr;
        logic [3:0] bus_addr;
        logic [31:0] rdata;
    } pic_state_t;

endpackage

// [logic/ext_trigger_detect.sv]
// external pin level or falling-edge detector with its request flag
`timescale 1ns/1ns

module ext_trigger_detect (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin,
    input wire logic trigger_select,
    input wire logic flag_set,
    input wire logic flag_clear,
    output logic request_flag
);
    import pic_pkg::*;

    detect_state_t state;
    detect_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.pin_q = pin;
        if (!trigger_select) begin
            // level mode: the source owns the flag, inverted pin each cycle
            next_state.flag = ~pin | flag_set; // [RULE10] [RULE13]
        end else if ((state.pin_q && !pin) || flag_set) begin
            // set wins over a clear landing in the same cycle
            next_state.flag = 1'b1; // [RULE10] [RULE13]
        end else if (flag_clear) begin
            next_state.flag = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= '{pin_q: 1'b1, flag: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign request_flag = state.flag;

endmodule

// [logic/priority_interrupt_controller.sv]
// two-level priority interrupt controller with an AHB-Lite register slave
// Function
// RULE1: same level resolved by fixed polling order
// RULE2: sample flags each cycle, poll next cycle
// RULE3: block call on level, unfinished, return_from_interrupt/register
// RULE4: one more instruction after return_from_interrupt or register
// RULE5: blocked requests are not remembered
// RULE6: call pushes pc, loads fixed source vector
// RULE7: clear only timer and edge external flags
// RULE8: return_from_interrupt ends level, then pops pc
// RULE9: plain return pops pc, keeps level
// RULE10: trigger select picks low level or fall
// RULE11: source holds pin levels one cycle
// RULE12: level source releases before routine ends
// RULE13: pins inverted and latched every cycle
// RULE14: call takes two cycles, three before service
// RULE15: lone request answered within three to nine
// RULE16: high preempts low, never the reverse
// RULE17: per-source enable, level select, global enable
// RULE18: serial and timer2 requests are ORed flags
// RULE19: one in-progress flag per level
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "pic_cfg.svh"

module priority_interrupt_controller (
    input wire logic ref_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // external pins
    input wire logic ext0_pin,
    input wire logic ext1_pin,
    // peripheral request sources
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic receive_done_flag,
    input wire logic transmit_done_flag,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_external_flag,
    // cpu sequencer
    input wire logic instr_last_cycle,
    input wire logic instr_is_return_from_interrupt,
    input wire logic instr_touches_regs,
    input wire logic return_from_interrupt_done,
    input wire logic ret_done,
    output logic call_push_pc,
    output logic call_load_pc,
    output logic [15:0] call_vector,
    output logic pop_pc,
    output logic [1:0] level_in_progress
);
    import pic_pkg::*;

    pic_state_t state;
    pic_state_t next_state;

    logic ext0_request_flag;
    logic ext1_request_flag;
    logic [1:0] ext_set;
    logic [1:0] ext_clear;
    logic [1:0] ext_pins;
    logic [1:0] ext_flags;
    logic [5:0] raw_req;
    logic [5:0] enabled;
    logic [5:0] hi_req;
    logic [5:0] lo_req;
    logic blocked;
    logic ack;
    logic ack_hi;
    logic [2:0] ack_src;
    logic wr_tc;
    logic bus_take;

    // ----------------------------------------------------------------
    // external pin detectors
    // ----------------------------------------------------------------
    assign ext_pins = {ext1_pin, ext0_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ext
            ext_trigger_detect u_detect (
                .ref_clk(ref_clk),
                .rst(rst),
                .pin(ext_pins[gi]),
                .trigger_select(state.trigger[gi]),
                .flag_set(ext_set[gi]),
                .flag_clear(ext_clear[gi]),
                .request_flag(ext_flags[gi])
            );
        end
    endgenerate

    assign ext0_request_flag = ext_flags[0];
    assign ext1_request_flag = ext_flags[1];

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] vector_of(input logic [2:0] src);
        logic [15:0] v;
        v = `VEC_EXT0;
        case (src)
            3'h0: v = `VEC_EXT0;
            3'h1: v = `VEC_TIMER0;
            3'h2: v = `VEC_EXT1;
            3'h3: v = `VEC_TIMER1;
            3'h4: v = `VEC_SERIAL;
            3'h5: v = `VEC_TIMER2;
            default: v = `VEC_EXT0;
        endcase
        return v;
    endfunction

    // lowest index wins: ext0, timer0, ext1, timer1, serial, timer2
    function automatic logic [2:0] first_set(input logic [5:0] req);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (req[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.pop_pc = 1'b0;

        // raw request lines in polling order
        raw_req = {timer2_overflow_flag | timer2_external_flag, // [RULE18]
                   receive_done_flag | transmit_done_flag, // [RULE18]
                   state.timer1_flag,
                   ext1_request_flag,
                   state.timer0_flag,
                   ext0_request_flag};
        // evaluation only ever sees last cycle's snapshot
        next_state.sample = raw_req; // [RULE2]

        enabled = state.sample & state.enable[5:0]
                  & {6{state.enable[`EN_GLOBAL_BIT]}}; // [RULE17]
        hi_req = enabled & state.level_select; // [RULE17]
        lo_req = enabled & ~state.level_select;

        // register access and return_from_interrupt push the call past
        // the next whole instruction
        blocked = !instr_last_cycle || instr_is_return_from_interrupt || instr_touches_regs
                  || state.call != CALL_IDLE; // [RULE3] [RULE4]

        // high level beats low; high in progress blocks all; low in
        // progress blocks only low
        ack_hi = 1'b0;
        ack = 1'b0;
        ack_src = 3'h0;
        if (!blocked && !state.in_prog_hi && |hi_req) begin // [RULE16] [RULE19]
            ack = 1'b1;
            ack_hi = 1'b1;
            ack_src = first_set(hi_req); // [RULE1]
        end else if (!blocked && !state.in_prog_hi && !state.in_prog_lo
                     && |lo_req) begin // [RULE16] [RULE19] [RULE3]
            ack = 1'b1;
            ack_src = first_set(lo_req); // [RULE1]
        end
        // nothing is held over: a blocked request is re-polled from the
        // fresh snapshot only [RULE5]

        // bus address phase
        bus_take = hsel && htrans[1] && hready;
        next_state.bus_wr = bus_take && hwrite && hsize == 3'b010;
        next_state.bus_addr = haddr[3:0];
        if (bus_take && !hwrite) begin
            if (haddr[3:0] == `OFS_ENABLE) begin
                next_state.rdata = {24'h000000, state.enable};
            end else if (haddr[3:0] == `OFS_PRIORITY) begin
                next_state.rdata = {26'h0, state.level_select};
            end else if (haddr[3:0] == `OFS_TIMER_CONTROL) begin
                next_state.rdata = {24'h000000, state.timer1_flag, 1'b0,
                                    state.timer0_flag, 1'b0,
                                    ext1_request_flag, state.trigger[1],
                                    ext0_request_flag, state.trigger[0]};
            end else if (haddr[3:0] == `OFS_STATUS) begin
                next_state.rdata = {16'h0000, 2'h0, state.sample, 6'h00,
                                    state.in_prog_lo, state.in_prog_hi};
            end else begin
                next_state.rdata = 32'h00000000;
            end
        end

        // bus data phase writes
        wr_tc = state.bus_wr && state.bus_addr == `OFS_TIMER_CONTROL;
        if (state.bus_wr && state.bus_addr == `OFS_ENABLE) begin
            next_state.enable = hwdata[7:0]; // [RULE17]
        end
        if (state.bus_wr && state.bus_addr == `OFS_PRIORITY) begin
            next_state.level_select = hwdata[5:0]; // [RULE17]
        end
        if (wr_tc) begin
            next_state.trigger = {hwdata[`TC_EXT1_TRIG_BIT],
                                  hwdata[`TC_EXT0_TRIG_BIT]};
        end

        // external flags: software sets, or clears in edge mode only; an edge-mode ack clears
        ext_set = {wr_tc && hwdata[`TC_EXT1_FLAG_BIT],
                   wr_tc && hwdata[`TC_EXT0_FLAG_BIT]};
        ext_clear[0] = (wr_tc && !hwdata[`TC_EXT0_FLAG_BIT])
                       || (ack && ack_src == 3'h0 && state.trigger[0]); // [RULE7]
        ext_clear[1] = (wr_tc && !hwdata[`TC_EXT1_FLAG_BIT])
                       || (ack && ack_src == 3'h2 && state.trigger[1]); // [RULE7]

        // timer flags: overflow wins over any clear in the same cycle
        if (timer0_overflow || (wr_tc && hwdata[`TC_TIMER0_FLAG_BIT])) begin
            next_state.timer0_flag = 1'b1;
        end else if (wr_tc || (ack && ack_src == 3'h1)) begin
            next_state.timer0_flag = 1'b0; // [RULE7]
        end
        if (timer1_overflow || (wr_tc && hwdata[`TC_TIMER1_FLAG_BIT])) begin
            next_state.timer1_flag = 1'b1;
        end else if (wr_tc || (ack && ack_src == 3'h3)) begin
            next_state.timer1_flag = 1'b0; // [RULE7]
        end
        // serial and timer2 flags are never touched here [RULE7]

        // hardware call sequencer: push cycle, then load cycle
        case (state.call)
            CALL_IDLE: begin
                if (ack) begin
                    next_state.call = CALL_PUSH; // [RULE14] [RULE15]
                    next_state.vector = vector_of(ack_src); // [RULE6]
                    if (ack_hi) begin
                        next_state.in_prog_hi = 1'b1; // [RULE19]
                    end else begin
                        next_state.in_prog_lo = 1'b1; // [RULE19]
                    end
                end
            end
            CALL_PUSH: begin
                next_state.call = CALL_LOAD; // [RULE14]
            end
            CALL_LOAD: begin
                next_state.call = CALL_IDLE;
            end
            default: begin
                next_state.call = CALL_IDLE;
            end
        endcase

        // returns: return_from_interrupt ends the innermost level, plain return does not
        if (return_from_interrupt_done) begin
            if (state.in_prog_hi) begin
                next_state.in_prog_hi = 1'b0; // [RULE8]
            end else begin
                next_state.in_prog_lo = 1'b0; // [RULE8]
            end
            next_state.pop_pc = 1'b1; // [RULE8]
        end else if (ret_done) begin
            next_state.pop_pc = 1'b1; // [RULE9]
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= '{enable: `ENABLE_RESET,
                       level_select: `PRIORITY_RESET,
                       trigger: `TRIGGER_RESET,
                       timer0_flag: 1'b0,
                       timer1_flag: 1'b0,
                       sample: 6'h00,
                       in_prog_hi: 1'b0,
                       in_prog_lo: 1'b0,
                       call: CALL_IDLE,
                       vector: 16'h0000,
                       pop_pc: 1'b0,
                       bus_wr: 1'b0,
                       bus_addr: 4'h0,
                       rdata: 32'h00000000};
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // zero wait states: every access completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state.rdata;
    assign call_push_pc = state.call == CALL_PUSH; // [RULE6]
    assign call_load_pc = state.call == CALL_LOAD; // [RULE6]
    assign call_vector = state.vector;
    assign pop_pc = state.pop_pc;
    assign level_in_progress = {state.in_prog_hi, state.in_prog_lo};

endmodule

// [sim/pic_assertions.sv]
// checker for the call, return and in-progress outputs
`timescale 1ns/1ns
`include "pic_cfg.svh"

module pic_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic instr_last_cycle,
    input wire logic instr_is_return_from_interrupt,
    input wire logic instr_touches_regs,
    input wire logic return_from_interrupt_done,
    input wire logic ret_done,
    input wire logic call_push_pc,
    input wire logic call_load_pc,
    input wire logic [15:0] call_vector,
    input wire logic pop_pc,
    input wire logic [1:0] level_in_progress
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_load; call_push_pc |=> call_load_pc && !call_push_pc; endproperty
    a_load: assert property (p_load)
        else $error("no load after push");
    property p_push; call_load_pc |-> $past(call_push_pc) && $stable(call_vector); endproperty
    a_push: assert property (p_push)
        else $error("load without push");
    property p_poll;
        $rose(call_push_pc) |-> $past(instr_last_cycle) && !$past(instr_is_return_from_interrupt)
            && !$past(instr_touches_regs);
    endproperty
    a_poll: assert property (p_poll)
        else $error("call while blocked");
    property p_high; $rose(call_push_pc) |-> ($past(level_in_progress) & 2'b10) == 2'b00; endproperty
    a_high: assert property (p_high)
        else $error("call over high routine");
    property p_nest;
        $rose(call_push_pc) && $past(level_in_progress) == 2'b01 |-> level_in_progress == 2'b11;
    endproperty
    a_nest: assert property (p_nest)
        else $error("low preempted low");
    property p_vec;
        call_push_pc |-> call_vector inside {`VEC_EXT0, `VEC_TIMER0, `VEC_EXT1,
            `VEC_TIMER1, `VEC_SERIAL, `VEC_TIMER2};
    endproperty
    a_vec: assert property (p_vec)
        else $error("bad vector");
    property p_return_from_interrupt; return_from_interrupt_done && level_in_progress[1] |=> !level_in_progress[1] && pop_pc; endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt)
        else $error("return_from_interrupt kept level");
    property p_ret;
        ret_done && !return_from_interrupt_done |=> pop_pc && ($past(level_in_progress) & ~level_in_progress) == 2'b00;
    endproperty
    a_ret: assert property (p_ret)
        else $error("ret changed level");
    property p_set;
        $rose(level_in_progress[0]) || $rose(level_in_progress[1]) |-> $rose(call_push_pc);
    endproperty
    a_set: assert property (p_set)
        else $error("level set without call");
endmodule

bind priority_interrupt_controller pic_assertions pic_assertions_inst (
    .ref_clk(ref_clk), .rst(rst), .instr_last_cycle(instr_last_cycle),
    .instr_is_return_from_interrupt(instr_is_return_from_interrupt), .instr_touches_regs(instr_touches_regs),
    .return_from_interrupt_done(return_from_interrupt_done), .ret_done(ret_done), .call_push_pc(call_push_pc),
    .call_load_pc(call_load_pc), .call_vector(call_vector), .pop_pc(pop_pc),
    .level_in_progress(level_in_progress)
);

// [sim/cpu_sequencer_model.sv]
// behavioural cpu sequencer that runs instructions of a chosen kind and length
`timescale 1ns/1ns

module cpu_sequencer_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] kind,
    input wire logic [1:0] len,
    input wire logic call_push_pc,
    input wire logic call_load_pc,
    output logic instr_last_cycle,
    output logic instr_is_return_from_interrupt,
    output logic instr_touches_regs,
    output logic return_from_interrupt_done,
    output logic ret_done
);
    // ----------------------------------------------------------------
    // instruction timing
    // ----------------------------------------------------------------
    logic [1:0] cnt;
    logic busy;
    // the hardware call replaces instructions, so none ends while it runs
    assign busy = call_push_pc | call_load_pc;
    assign instr_last_cycle = !busy && cnt == len;
    assign instr_is_return_from_interrupt = kind == 2'h1;
    assign instr_touches_regs = kind == 2'h2;
    assign return_from_interrupt_done = instr_last_cycle && kind == 2'h1;
    assign ret_done = instr_last_cycle && kind == 2'h3;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= 2'h0;
        end else if (busy || instr_last_cycle) begin
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule

// [sim/tb.sv]
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ns
`include "pic_cfg.svh"

module tb;
    typedef struct packed {
        logic [7:0] mask;
        logic [5:0] prio;
        logic [15:0] vec;
        logic [1:0] lvl;
    } row_t;
    logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0, kind = 0, len = 0, lvl;
    logic [2:0] hsize = 3'h2;
    // pins idle high, pulses and levels idle low
    logic [7:0] src = 8'h05;
    logic last, return_from_interrupt, regs, retid, retd, push, load, pop;
    logic [15:0] vec;
    int bad_count = 0, checks_done = 0, n;
    row_t rows[12] = '{'{8'h01, 6'h00, 16'h0003, 2'h1}, '{8'h02, 6'h3F, 16'h000B, 2'h2},
        '{8'h04, 6'h00, 16'h0013, 2'h1}, '{8'h08, 6'h3F, 16'h001B, 2'h2},
        '{8'h10, 6'h00, 16'h0023, 2'h1}, '{8'h40, 6'h3F, 16'h0023, 2'h2},
        '{8'h20, 6'h00, 16'h002B, 2'h1}, '{8'h80, 6'h3F, 16'h002B, 2'h2},
        '{8'hFF, 6'h00, 16'h0003, 2'h1}, '{8'hFA, 6'h00, 16'h000B, 2'h1},
        '{8'hF0, 6'h00, 16'h0023, 2'h1}, '{8'h21, 6'h20, 16'h002B, 2'h2}};

    priority_interrupt_controller priority_interrupt_controller_inst (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .ext0_pin(src[0]),
        .ext1_pin(src[2]), .timer0_overflow(src[1]), .timer1_overflow(src[3]),
        .receive_done_flag(src[4]), .transmit_done_flag(src[6]),
        .timer2_overflow_flag(src[5]), .timer2_external_flag(src[7]),
        .instr_last_cycle(last), .instr_is_return_from_interrupt(return_from_interrupt), .instr_touches_regs(regs),
        .return_from_interrupt_done(retid), .ret_done(retd), .call_push_pc(push), .call_load_pc(load),
        .call_vector(vec), .pop_pc(pop), .level_in_progress(lvl));
    cpu_sequencer_model cpu_sequencer_model_inst (
        .ref_clk(ref_clk), .rst(rst), .kind(kind), .len(len), .call_push_pc(push),
        .call_load_pc(load), .instr_last_cycle(last), .instr_is_return_from_interrupt(return_from_interrupt),
        .instr_touches_regs(regs), .return_from_interrupt_done(retid), .ret_done(retd));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    always #4 ref_clk = ~ref_clk;
    task complete_run;
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // sel 0 waits for a call at negedges, 1 for an instruction end, 2 for hready at posedges
    task wait_for(input int sel, input int lim);
        n = 0;
        if (sel == 2) @(posedge ref_clk);
        else @(negedge ref_clk);
        while ((sel == 0 ? push : sel == 1 ? last : hready) !== 1'b1) begin
            if (++n > lim) begin
                bad_count++;
                complete_run();
            end
            if (sel == 2) @(posedge ref_clk);
            else @(negedge ref_clk);
        end
    endtask
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_for(2, 20);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_for(2, 20);
        rd = hrdata;
    endtask
    // levels follow a cycle late: pins and pulses pass a flag register first,
    // so every source of one call lands in the same sample
    task raise(input logic [7:0] m);
        @(posedge ref_clk);
        src <= (m & 8'h0F) ^ 8'h05;
        @(posedge ref_clk);
        src <= (m ^ 8'h05) & 8'hF5;
    endtask
    task instr(input logic [1:0] k);
        @(posedge ref_clk);
        kind <= k;
        wait_for(1, 20);
        @(posedge ref_clk);
        kind <= 2'h0;
    endtask
    task no_push;
        repeat (12) begin
            @(negedge ref_clk);
            check(push, 0);
        end
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 0;
        @(negedge ref_clk);
        check({hready, hresp, push, load, pop, lvl}, 32'h40);
        for (int i = 0; i < 4; i++) begin
            bus(0, i * 4, 0);
            check(rd, 0);
        end
        bus(1, `OFS_ENABLE, 32'hBF);
        foreach (rows[i]) begin
            bus(1, `OFS_PRIORITY, rows[i].prio);
            raise(rows[i].mask);
            wait_for(0, 20);
            check(vec, rows[i].vec);
            check(lvl, rows[i].lvl);
            @(negedge ref_clk);
            check(load, 1);
            raise(8'h00);
            bus(1, `OFS_TIMER_CONTROL, 0);
            instr(1);
            @(negedge ref_clk);
            check(lvl, 0);
        end
        // falling edge on ext0: latency, flag clearing, no retrigger
        bus(1, `OFS_TIMER_CONTROL, 32'h01);
        bus(1, `OFS_PRIORITY, 0);
        src[0] <= 0;
        wait_for(0, 20);
        check(n >= 2 && n <= 6, 1);
        check(vec, 16'h0003);
        bus(0, `OFS_TIMER_CONTROL, 0);
        check(rd, 32'h01);
        instr(1);
        no_push();
        // global enable off, then one source alone
        bus(1, `OFS_ENABLE, 32'h3F);
        bus(1, `OFS_TIMER_CONTROL, 0);
        raise(8'h03);
        bus(0, `OFS_TIMER_CONTROL, 0);
        check(rd, 32'h22);
        no_push();
        bus(1, `OFS_ENABLE, 32'h82);
        wait_for(0, 20);
        check(vec, 16'h000B);
        raise(8'h00);
        bus(1, `OFS_ENABLE, 32'hBF);
        bus(1, `OFS_TIMER_CONTROL, 0);
        instr(1);
        // register access blocks, held flag is served later, dropped level is not
        @(posedge ref_clk);
        kind <= 2'h2;
        len <= 2'h1;
        raise(8'h02);
        no_push();
        // drop the register kind at an instruction boundary: the next
        // two-cycle instruction must still finish before the call
        wait_for(1, 20);
        @(posedge ref_clk);
        kind <= 2'h0;
        wait_for(0, 12);
        check(n, 2);
        check(vec, 16'h000B);
        instr(1);
        @(posedge ref_clk);
        kind <= 2'h2;
        raise(8'h01);
        raise(8'h00);
        repeat (3) @(posedge ref_clk);
        kind <= 2'h0;
        no_push();
        // high preempts low, low does not, plain return keeps the level
        bus(1, `OFS_PRIORITY, 32'h02);
        raise(8'h01);
        wait_for(0, 20);
        raise(8'h08);
        no_push();
        raise(8'h02);
        wait_for(0, 20);
        check({lvl, vec}, 32'h3000B);
        bus(1, `OFS_TIMER_CONTROL, 0);
        instr(3);
        @(negedge ref_clk);
        check(lvl, 2'h3);
        instr(1);
        @(negedge ref_clk);
        check(lvl, 2'h1);
        instr(1);
        @(negedge ref_clk);
        check(lvl, 0);
        complete_run();
    end
endmodule
